// *** pkg/fifo_flag_pkg.sv ***
// constants and carrier types for the flag-timing fifo
package fifo_flag_pkg;

    // ------------------------------------------------------------------
    // data path geometry
    // ------------------------------------------------------------------
    localparam int DATA_WIDTH = 18;
    localparam int FIFO_DEPTH = 32;
    localparam int PTR_WIDTH  = 5;
    localparam int CNT_WIDTH  = PTR_WIDTH + 1;
    localparam logic [CNT_WIDTH-1:0] DEPTH_COUNT = 6'h20;

    // ------------------------------------------------------------------
    // timing, clk_sys at 25 MHz
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 40;
    localparam int REWIND_PULSE_NS   = 60;
    localparam int REWIND_RECOVER_NS = 90;
    // least time: round up
    localparam int REWIND_PULSE_CYCLES =
        (REWIND_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest time: round down, never below one cycle
    localparam int REWIND_RECOVER_CYCLES =
        (REWIND_RECOVER_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (REWIND_RECOVER_NS / CLK_PERIOD_NS);
    localparam int TIMER_WIDTH = 3;

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    localparam int REG_ADDR_WIDTH = 4;
    localparam int REG_DATA_WIDTH = 32;
    localparam logic [REG_ADDR_WIDTH-1:0] ALMOST_EMPTY_OFFSET_ADDR = 4'h0;
    localparam logic [REG_ADDR_WIDTH-1:0] ALMOST_FULL_OFFSET_ADDR  = 4'h4;
    localparam logic [REG_ADDR_WIDTH-1:0] STATUS_ADDR              = 4'h8;
    localparam logic [REG_ADDR_WIDTH-1:0] CONTROL_ADDR             = 4'hC;
    localparam logic [CNT_WIDTH-1:0] ALMOST_EMPTY_OFFSET_RESET = 6'h04;
    localparam logic [CNT_WIDTH-1:0] ALMOST_FULL_OFFSET_RESET  = 6'h04;
    // status field positions
    localparam int STAT_COUNT_LSB   = 0;
    localparam int STAT_FLAGS_LSB   = 8;
    localparam int STAT_RECOVER_BIT = 12;
    localparam int STAT_MODE_BIT    = 13;
    // control field positions
    localparam int CTRL_REWIND_BIT  = 0;

    // active-low flag group, as seen on the pins
    typedef struct packed {
        logic almost_full_n;
        logic almost_empty_n;
        logic full_n;
        logic empty_n;
    } flags_s;

    localparam flags_s FLAGS_RESET = 4'hA;

endpackage

// *** hdl/fifo_store.sv ***
// word store with pointers, fill count and rewind
`timescale 1ns/1ps
`default_nettype none

module fifo_store
    import fifo_flag_pkg::*;
#(
    parameter int WIDTH = DATA_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire logic [WIDTH-1:0]  in_data,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic [WIDTH-1:0]       out_data,
    input  wire logic              rewind,
    output logic [$clog2(DEPTH):0] fill,
    output logic [$clog2(DEPTH):0] rewind_fill
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL_LEVEL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    written;
    wire              push;
    wire              pop;

    assign in_ready    = (fill != FULL_LEVEL);
    assign out_valid   = (fill != '0);
    assign push        = in_valid & in_ready & ~rewind;
    assign pop         = out_valid & out_ready & ~rewind;
    assign rewind_fill = written;

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // read data come from a register; zero after reset
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            out_data <= '0;
        else if (pop)
            out_data <= mem[rd_ptr];
    end

    // ------------------------------------------------------------------
    // pointers
    // ------------------------------------------------------------------
    // rewind replays from zero; exact only until DEPTH words were written
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            fill    <= '0;
            written <= '0;
        end
        else if (rewind)
        begin
            rd_ptr <= '0;
            fill   <= written;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + AW'(1);
            if (pop)
                rd_ptr <= rd_ptr + AW'(1);
            if (push && written != FULL_LEVEL)
                written <= written + CW'(1);
            fill <= fill + CW'(push) - CW'(pop);
        end
    end

endmodule

`default_nettype wire

// *** hdl/fifo_flag_timing.sv ***
// single-clock fifo with full, empty and programmable almost flags
//
// Contract
// - after reset data read low with enable low and float with it high.
// - both clocks may run freely during reset.
// - the first word reaches the read port the read edge after empty clears.
// - full clears on the write edge after a read, at most one edge late.
// - empty clears on the read edge after a write, at most one edge late.
// - first-word latency at the empty boundary is one or two read periods.
// - sync almost-empty updates on the read edge after the write or next.
// - sync almost-full updates on the write edge after the read or next.
// - almost-empty is active while the count is at or below offset n.
// - almost-full is active from depth minus m words, not at one fewer.
// - after a rewind the flags are valid within the recovery time.
// - sync almost flags refresh one edge after recovery, given by the user.
// - registered almost flags are used only while mode select is low.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module fifo_flag_timing
    import fifo_flag_pkg::*;
(
    input  wire logic                      clk_sys,
    input  wire logic                      rst_b,
    // write side
    input  wire logic                      write_enable,
    input  wire logic [DATA_WIDTH-1:0]     write_data,
    // read side
    input  wire logic                      read_enable,
    input  wire logic                      output_enable_n,
    output logic [DATA_WIDTH-1:0]          read_data,
    output logic                           read_data_oe_n,
    // flags, active low
    output logic                           full_flag_n,
    output logic                           empty_flag_n,
    output logic                           almost_empty_flag_n,
    output logic                           almost_full_flag_n,
    // mode and rewind
    input  wire logic                      flag_sync_select,
    input  wire logic                      rewind_request,
    // register port
    input  wire logic [REG_ADDR_WIDTH-1:0] reg_addr,
    input  wire logic [REG_DATA_WIDTH-1:0] reg_wdata,
    input  wire logic                      reg_write,
    input  wire logic                      reg_read,
    output logic [REG_DATA_WIDTH-1:0]      reg_rdata
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic almost_empty_hit(
        input logic [CNT_WIDTH-1:0] count,
        input logic [CNT_WIDTH-1:0] offset
    );
        return (count <= offset);
    endfunction

    function automatic logic almost_full_hit(
        input logic [CNT_WIDTH-1:0] count,
        input logic [CNT_WIDTH-1:0] offset
    );
        // compare count + m >= depth, widened so no wrap occurs
        logic [CNT_WIDTH:0] total;
        total = {1'b0, count} + {1'b0, offset};
        return (total >= {1'b0, DEPTH_COUNT});
    endfunction

    function automatic logic [CNT_WIDTH-1:0] step_count(
        input logic [CNT_WIDTH-1:0] count,
        input logic                 inc,
        input logic                 dec
    );
        return count + CNT_WIDTH'(inc) - CNT_WIDTH'(dec);
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RUN,
        RECOVER,
        SETTLE
    } rewind_state_e;

    rewind_state_e            rewind_state;
    rewind_state_e            next_rewind_state;
    logic [TIMER_WIDTH-1:0]   recover_timer;
    logic [TIMER_WIDTH-1:0]   pulse_timer;
    logic                     pulse_taken;
    logic [CNT_WIDTH-1:0]     almost_empty_offset;
    logic [CNT_WIDTH-1:0]     almost_full_offset;
    logic                     soft_rewind;
    flags_s                   flags;
    flags_s                   next_flags;
    logic                     almost_empty_async_n;
    logic                     almost_full_async_n;

    wire [CNT_WIDTH-1:0]      fill;
    wire [CNT_WIDTH-1:0]      rewind_fill;
    wire                      store_in_ready;
    wire                      store_out_valid;
    wire [DATA_WIDTH-1:0]     store_out_data;
    wire                      busy;
    wire                      write_go;
    wire                      read_go;
    wire                      pin_rewind;
    wire                      rewind_go;
    wire [CNT_WIDTH-1:0]      next_count;
    wire                      wr_ae_offset;
    wire                      wr_af_offset;
    wire                      wr_control;
    wire [REG_DATA_WIDTH-1:0] status_word;
    wire [REG_DATA_WIDTH-1:0] read_mux;

    // ------------------------------------------------------------------
    // word store
    // ------------------------------------------------------------------
    fifo_store #(
        .WIDTH (DATA_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_store (
        .clk_sys     (clk_sys),
        .rst_b       (rst_b),
        .in_valid    (write_go),
        .in_ready    (store_in_ready),
        .in_data     (write_data),
        .out_valid   (store_out_valid),
        .out_ready   (read_go),
        .out_data    (store_out_data),
        .rewind      (rewind_go),
        .fill        (fill),
        .rewind_fill (rewind_fill)
    );

    // ------------------------------------------------------------------
    // accept and refuse
    // ------------------------------------------------------------------
    // both sides stall while a rewind realigns the pointers
    assign busy     = (rewind_state != RUN);
    // the store's own ready backs the pin flag, so a late flag loses nothing
    assign write_go = write_enable & full_flag_n & store_in_ready
                      & ~busy;
    assign read_go  = read_enable & empty_flag_n & store_out_valid
                      & ~busy;

    assign next_count = rewind_go ? rewind_fill
                                  : step_count(fill, write_go, read_go);

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    // store output register: zero after reset, popped word after a read
    assign read_data      = store_out_data;
    assign read_data_oe_n = output_enable_n;

    // ------------------------------------------------------------------
    // flags
    // ------------------------------------------------------------------
    // one clock drives both ports, so every edge meets the skew windows
    always_comb
    begin
        next_flags                = flags;
        next_flags.empty_n        = (next_count != '0);
        next_flags.full_n         = (next_count != DEPTH_COUNT);
        next_flags.almost_empty_n =
            ~almost_empty_hit(next_count, almost_empty_offset);
        next_flags.almost_full_n  =
            ~almost_full_hit(next_count, almost_full_offset);
    end

    // reset works without the clock, so free-running clocks do no harm
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            flags <= FLAGS_RESET;
        else
            flags <= next_flags;
    end

    // async mode decodes the count register directly
    assign almost_empty_async_n =
        ~almost_empty_hit(fill, almost_empty_offset);
    assign almost_full_async_n  =
        ~almost_full_hit(fill, almost_full_offset);

    assign full_flag_n         = flags.full_n;
    assign empty_flag_n        = flags.empty_n;
    assign almost_empty_flag_n = flag_sync_select
                                 ? almost_empty_async_n
                                 : flags.almost_empty_n;
    assign almost_full_flag_n  = flag_sync_select
                                 ? almost_full_async_n
                                 : flags.almost_full_n;

    // ------------------------------------------------------------------
    // rewind
    // ------------------------------------------------------------------
    // a pin request counts once held for the least pulse width, once per hold
    assign pin_rewind = rewind_request & ~pulse_taken
                        & (pulse_timer
                           == TIMER_WIDTH'(REWIND_PULSE_CYCLES - 1));
    assign rewind_go  = (pin_rewind | soft_rewind) & ~busy;

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pulse_timer <= '0;
            pulse_taken <= 1'b0;
        end
        else if (!rewind_request)
        begin
            pulse_timer <= '0;
            pulse_taken <= 1'b0;
        end
        else
        begin
            if (pulse_timer != TIMER_WIDTH'(REWIND_PULSE_CYCLES - 1))
                pulse_timer <= pulse_timer + TIMER_WIDTH'(1);
            if (pin_rewind)
                pulse_taken <= 1'b1;
        end
    end

    always_comb
    begin
        next_rewind_state = rewind_state;
        unique case (rewind_state)
            RUN:
                if (rewind_go)
                    next_rewind_state = RECOVER;
            RECOVER:
                if (recover_timer == TIMER_WIDTH'(1))
                    next_rewind_state = SETTLE;
            SETTLE:
                // one more edge so the registered almost flags refresh
                next_rewind_state = RUN;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rewind_state  <= RUN;
            recover_timer <= '0;
        end
        else
        begin
            rewind_state <= next_rewind_state;
            if (rewind_go)
                recover_timer <= TIMER_WIDTH'(REWIND_RECOVER_CYCLES - 1);
            else if (recover_timer != '0)
                recover_timer <= recover_timer - TIMER_WIDTH'(1);
        end
    end

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    assign wr_ae_offset = reg_write & (reg_addr == ALMOST_EMPTY_OFFSET_ADDR);
    assign wr_af_offset = reg_write & (reg_addr == ALMOST_FULL_OFFSET_ADDR);
    assign wr_control   = reg_write & (reg_addr == CONTROL_ADDR);

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            almost_empty_offset <= ALMOST_EMPTY_OFFSET_RESET;
            almost_full_offset  <= ALMOST_FULL_OFFSET_RESET;
        end
        else
        begin
            if (wr_ae_offset)
                almost_empty_offset <= reg_wdata[CNT_WIDTH-1:0];
            if (wr_af_offset)
                almost_full_offset <= reg_wdata[CNT_WIDTH-1:0];
        end
    end

    // a control write asks for one rewind on the following edge
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            soft_rewind <= 1'b0;
        else
            soft_rewind <= wr_control & reg_wdata[CTRL_REWIND_BIT];
    end

    assign status_word =
        (REG_DATA_WIDTH'(fill) << STAT_COUNT_LSB)
        | (REG_DATA_WIDTH'(flags) << STAT_FLAGS_LSB)
        | (REG_DATA_WIDTH'(busy) << STAT_RECOVER_BIT)
        | (REG_DATA_WIDTH'(flag_sync_select) << STAT_MODE_BIT);

    assign read_mux =
        (reg_addr == ALMOST_EMPTY_OFFSET_ADDR)
            ? REG_DATA_WIDTH'(almost_empty_offset) :
        (reg_addr == ALMOST_FULL_OFFSET_ADDR)
            ? REG_DATA_WIDTH'(almost_full_offset) :
        (reg_addr == STATUS_ADDR) ? status_word : '0;

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= '0;
        else if (reg_read)
            reg_rdata <= read_mux;
        else
            reg_rdata <= '0;
    end

endmodule

`default_nettype wire

// *** verif/fifo_flag_timing_asserts.sv ***
// concurrent checks on the flag-timing fifo ports
`timescale 1ns/1ps
`default_nettype none

module fifo_flag_timing_asserts
    import fifo_flag_pkg::*;
(
    input wire logic                      clk_sys,
    input wire logic                      rst_b,
    input wire logic                      write_enable,
    input wire logic [DATA_WIDTH-1:0]     write_data,
    input wire logic                      read_enable,
    input wire logic                      output_enable_n,
    input wire logic [DATA_WIDTH-1:0]     read_data,
    input wire logic                      read_data_oe_n,
    input wire logic                      full_flag_n,
    input wire logic                      empty_flag_n,
    input wire logic                      almost_empty_flag_n,
    input wire logic                      almost_full_flag_n,
    input wire logic                      flag_sync_select,
    input wire logic                      rewind_request,
    input wire logic [REG_ADDR_WIDTH-1:0] reg_addr,
    input wire logic                      reg_write,
    input wire logic                      reg_read,
    input wire logic [REG_DATA_WIDTH-1:0] reg_rdata
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // --------------------------------------------------------------
    // quiet: no rewind can be pending or recovering
    // --------------------------------------------------------------
    logic [2:0] quiet_cnt;
    logic       quiet;
    assign quiet = (quiet_cnt >= 3'h5);
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            quiet_cnt <= 3'h0;
        else if (rewind_request || reg_write)
            quiet_cnt <= 3'h0;
        else if (quiet_cnt != 3'h7)
            quiet_cnt <= quiet_cnt + 3'h1;
    end

    // --------------------------------------------------------------
    // properties
    // --------------------------------------------------------------
    sequence s_first_wr;
        quiet && !empty_flag_n && write_enable;
    endsequence
    sequence s_first_rd;
        quiet && read_enable;
    endsequence
    property p_oe_follow;
        read_data_oe_n == output_enable_n;
    endproperty
    property p_first_word;
        s_first_wr ##1 s_first_rd |=> read_data == $past(write_data, 2);
    endproperty
    property p_empty_clear;
        quiet && !empty_flag_n && write_enable |=> empty_flag_n;
    endproperty
    property p_full_clear;
        quiet && !full_flag_n && read_enable |=> full_flag_n;
    endproperty
    property p_full_hold;
        quiet && !full_flag_n && !read_enable |=> !full_flag_n;
    endproperty
    property p_empty_hold;
        quiet && !empty_flag_n && !write_enable |=> !empty_flag_n;
    endproperty
    property p_ae_on_empty;
        quiet && !empty_flag_n |-> !almost_empty_flag_n;
    endproperty
    property p_af_on_full;
        quiet && !full_flag_n |-> !almost_full_flag_n;
    endproperty
    property p_mode_status;
        reg_read && reg_addr == STATUS_ADDR
            |=> reg_rdata[STAT_MODE_BIT] == $past(flag_sync_select);
    endproperty

    a_oe_follow: assert property (p_oe_follow)
        else $error("output enable not followed");
    a_first_word: assert property (p_first_word)
        else $error("first word late or wrong");
    a_empty_clear: assert property (p_empty_clear)
        else $error("empty not cleared by write");
    a_full_clear: assert property (p_full_clear)
        else $error("full not cleared by read");
    a_full_hold: assert property (p_full_hold)
        else $error("write accepted while full");
    a_empty_hold: assert property (p_empty_hold)
        else $error("read accepted while empty");
    a_ae_on_empty: assert property (p_ae_on_empty)
        else $error("almost empty inactive at zero words");
    a_af_on_full: assert property (p_af_on_full)
        else $error("almost full inactive while full");
    a_mode_status: assert property (p_mode_status)
        else $error("mode bit in status wrong");
endmodule

`default_nettype wire

// *** verif/stream_partner.sv ***
// write-side source and read-side enable of the far logic
`timescale 1ns/1ps
`default_nettype none

module stream_partner
    import fifo_flag_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic             full_flag_n,
    output logic                  write_enable,
    output logic                  read_enable,
    output logic [DATA_WIDTH-1:0] write_data
);
    logic [DATA_WIDTH-1:0] wr_seq;

    assign write_enable = push;
    assign read_enable  = pop;
    // scrambled so stuck bits show up on the read side
    assign write_data   = wr_seq ^ 18'h2AAAA;

    // sequence moves on each push made while full_flag_n is high
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            wr_seq <= '0;
        else if (push && full_flag_n)
            wr_seq <= wr_seq + 18'h00001;
    end
endmodule

`default_nettype wire

// *** verif/fifo_flag_timing_tb_top.sv ***
// self-checking bench for the flag-timing fifo
`timescale 1ns/1ps
`default_nettype none

module fifo_flag_timing_tb_top;
    import fifo_flag_pkg::*;
    logic clk_sys, rst_b, push, pop, write_enable, read_enable;
    logic output_enable_n, read_data_oe_n, flag_sync_select;
    logic full_flag_n, empty_flag_n, almost_empty_flag_n;
    logic almost_full_flag_n, rewind_request, reg_write, reg_read;
    logic [DATA_WIDTH-1:0] write_data, read_data;
    logic [REG_ADDR_WIDTH-1:0] reg_addr;
    logic [REG_DATA_WIDTH-1:0] reg_wdata, reg_rdata, rd_val;
    int num_errors, compares;

    fifo_flag_timing dut (.clk_sys, .rst_b, .write_enable, .write_data,
        .read_enable, .output_enable_n, .read_data, .read_data_oe_n,
        .full_flag_n, .empty_flag_n, .almost_empty_flag_n,
        .almost_full_flag_n, .flag_sync_select, .rewind_request,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);
    stream_partner partner (.clk_sys, .rst_b, .push, .pop, .full_flag_n,
        .write_enable, .read_enable, .write_data);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [17:0] word(input int i);
        return DATA_WIDTH'(i) ^ 18'h2AAAA;
    endfunction
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(negedge clk_sys);
        rd_val = reg_rdata;
    endtask
    task automatic op(input logic w, input logic r);
        @(posedge clk_sys);
        push <= w;
        pop <= r;
        @(posedge clk_sys);
        push <= 1'b0;
        pop <= 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic close_out;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // whole run is under two hundred cycles
    initial
    begin
        #200000;
        num_errors++;
        close_out();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {rst_b, push, pop, output_enable_n, flag_sync_select} = '0;
        {rewind_request, reg_write, reg_read} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        num_errors = 0;
        compares = 0;
        repeat (12) @(posedge clk_sys);
        check("empty in reset", empty_flag_n, 0);
        check("full in reset", full_flag_n, 1);
        rst_b <= 1'b1;
        @(negedge clk_sys);
        check("data after reset", read_data, 0);
        output_enable_n <= 1'b1;
        @(negedge clk_sys);
        check("oe high", read_data_oe_n, 1);
        output_enable_n <= 1'b0;
        reg_wr(ALMOST_EMPTY_OFFSET_ADDR, 32'h3);
        reg_wr(ALMOST_FULL_OFFSET_ADDR, 32'h5);
        reg_rd(ALMOST_FULL_OFFSET_ADDR);
        check("af offset", rd_val, 32'h5);
        reg_rd(4'h2);
        check("unmapped", rd_val, 0);
        for (int k = 1; k <= 32; k++)
        begin
            op(1'b1, 1'b0);
            check("ae fill", almost_empty_flag_n, k > 3);
            check("af fill", almost_full_flag_n, k < 27);
            check("full fill", full_flag_n, k < 32);
        end
        op(1'b1, 1'b0);
        reg_rd(STATUS_ADDR);
        check("count full", rd_val[5:0], 6'h20);
        for (int k = 1; k <= 32; k++)
        begin
            op(1'b0, 1'b1);
            check("data order", read_data, word(k - 1));
            check("ae drain", almost_empty_flag_n, 32 - k > 3);
            check("empty drain", empty_flag_n, k < 32);
        end
        op(1'b0, 1'b1);
        check("read when empty", read_data, word(31));
        @(posedge clk_sys);
        push <= 1'b1;
        @(posedge clk_sys);
        push <= 1'b0;
        pop <= 1'b1;
        @(posedge clk_sys);
        pop <= 1'b0;
        @(negedge clk_sys);
        check("first word", read_data, word(32));
        check("empty again", empty_flag_n, 0);
        flag_sync_select <= 1'b1;
        op(1'b1, 1'b0);
        reg_wr(ALMOST_EMPTY_OFFSET_ADDR, 32'h0);
        check("ae async", almost_empty_flag_n, 1);
        reg_wr(ALMOST_EMPTY_OFFSET_ADDR, 32'h3);
        check("ae async 3", almost_empty_flag_n, 0);
        reg_rd(STATUS_ADDR);
        check("mode bit", rd_val[STAT_MODE_BIT], 1);
        flag_sync_select <= 1'b0;
        @(posedge clk_sys);
        rewind_request <= 1'b1;
        @(posedge clk_sys);
        @(posedge clk_sys);
        rewind_request <= 1'b0;
        reg_addr <= STATUS_ADDR;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(negedge clk_sys);
        check("recovering", reg_rdata[STAT_RECOVER_BIT], 1);
        // three spare edges after recovery so the registered almost flags refresh
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        check("full rewind", full_flag_n, 0);
        check("af rewind", almost_full_flag_n, 0);
        check("ae rewind", almost_empty_flag_n, 1);
        reg_wr(CONTROL_ADDR, 32'h1);
        reg_rd(STATUS_ADDR);
        check("ctrl recovering", rd_val[STAT_RECOVER_BIT], 1);
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        check("full ctrl rewind", full_flag_n, 0);
        close_out();
    end
endmodule

bind fifo_flag_timing fifo_flag_timing_asserts u_asserts (.clk_sys,
    .rst_b, .write_enable, .write_data, .read_enable, .output_enable_n,
    .read_data, .read_data_oe_n, .full_flag_n, .empty_flag_n,
    .almost_empty_flag_n, .almost_full_flag_n, .flag_sync_select,
    .rewind_request, .reg_addr, .reg_write, .reg_read, .reg_rdata);

`default_nettype wire
